/* File: hw/frame_layer.sv */
// frame layer: receive checks, response serialiser and page memory
// assumes rx strobes already decoded from the field, one bit per strobe
`timescale 1ns/100ps
`default_nettype none
module frame_layer
    import frame_layer_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // decoded receive bits
    input wire logic rx_sof,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_code_err,
    input wire logic rx_eof,
    // received bytes to the command processor
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_good,
    output logic rx_bad,
    output logic rx_short,
    // response bytes from the command processor
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    output logic rsp_ready,
    // page read stream
    input wire logic rd_req,
    input wire logic [5:0] rd_first,
    input wire logic [5:0] rd_last,
    input wire logic rd_range,
    output logic rd_busy,
    output logic rd_err,
    // page write
    input wire logic wr_req,
    input wire logic [5:0] wr_page,
    input wire logic [31:0] wr_data,
    output logic wr_done,
    output logic wr_deny,
    // modulator side
    output logic tx_line,
    output logic tx_active,
    output logic tx_done,
    output logic tx_len_err
);
    typedef struct packed {
        logic rx_on, rx_par, rx_err, rx_byte, rx_good, rx_bad, rx_short, tx_ok;
        logic [7:0] rx_sh, rx_data, tx_sh;
        logic [3:0] rx_cnt;
        logic [8:0] rx_bits;
        logic [15:0] rx_crc, tx_crc;
        logic [1:0][9:0] b_dat;
        logic [1:0] b_cnt, tx_cp, rd_by;
        logic b_wp, b_rp, tx_par, tx_last, tx_range, tx_drop, tx_line, tx_act, tx_done, tx_len_err;
        tx_st_t tx_st;
        logic [2:0] tx_i;
        logic [6:0] tx_tmr;
        logic [10:0] tx_bits;
        logic rd_on, rd_range, rd_err, wr_done, wr_deny;
        logic [5:0] rd_pg, rd_end;
        logic [59:0][31:0] mem;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic has, push, pop, ld, ld_first, ld_crc, lk;
    logic [9:0] head, push_dat;
    logic [7:0] ld_byte;
    logic [5:0] gi;
    logic [31:0] wold;

    assign has = s_q.b_cnt != 2'h0;
    assign head = s_q.b_dat[s_q.b_rp];
    // the page reader owns the buffer while it runs
    assign rsp_ready = !s_q.rd_on && s_q.b_cnt != 2'h2;

    always_comb begin
        s_d = s_q;
        pop = 1'b0;
        ld = 1'b0;
        ld_first = 1'b0;
        ld_crc = 1'b0;
        ld_byte = 8'h00;
        push = 1'b0;
        push_dat = 10'h000;
        lk = 1'b0;
        gi = 6'h00;
        wold = 32'h0000_0000;
        s_d.rx_byte = 1'b0;
        s_d.rx_good = 1'b0;
        s_d.rx_bad = 1'b0;
        s_d.tx_done = 1'b0;
        s_d.tx_len_err = 1'b0;
        s_d.rd_err = 1'b0;
        s_d.wr_done = 1'b0;
        s_d.wr_deny = 1'b0;

        // receive
        if (rx_sof) begin
            s_d.rx_on = 1'b1;
            s_d.rx_sh = 8'h00;
            s_d.rx_cnt = 4'h0;
            s_d.rx_par = 1'b0;
            s_d.rx_bits = 9'h000;
            s_d.rx_crc = CRC_INIT;
            s_d.rx_err = 1'b0;
            s_d.tx_ok = 1'b0;
        end else if (s_q.rx_on) begin
            if (rx_bit_valid) begin
                if (rx_code_err) s_d.rx_err = 1'b1;
                if (s_q.rx_cnt != 4'h8) begin
                    s_d.rx_sh = {rx_bit, s_q.rx_sh[7:1]};
                    s_d.rx_par = s_q.rx_par ^ rx_bit;
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    if (s_q.rx_bits == RX_MAX_BITS) begin
                        s_d.rx_err = 1'b1;
                    end else begin
                        s_d.rx_bits = s_q.rx_bits + 9'h001;
                    end
                end else begin
                    if (rx_bit == s_q.rx_par) s_d.rx_err = 1'b1;
                    s_d.rx_byte = 1'b1;
                    s_d.rx_data = s_q.rx_sh;
                    s_d.rx_crc = crc_byte(s_q.rx_crc, s_q.rx_sh);
                    s_d.rx_cnt = 4'h0;
                    s_d.rx_par = 1'b0;
                end
            end
            if (rx_eof) begin
                s_d.rx_on = 1'b0;
                s_d.rx_short = 1'b0;
                // short frames carry seven bits, no parity and no crc
                if (s_q.rx_bits == SHORT_BITS && s_q.rx_cnt == 4'h7 && !s_q.rx_err) begin
                    s_d.rx_byte = 1'b1;
                    s_d.rx_data = {1'b0, s_q.rx_sh[7:1]};
                    s_d.rx_good = 1'b1;
                    s_d.rx_short = 1'b1;
                    s_d.tx_ok = 1'b1;
                end else if (s_q.rx_cnt == 4'h0 && s_q.rx_bits >= MIN_CRC_BITS
                             && s_q.rx_crc == 16'h0000 && !s_q.rx_err) begin
                    s_d.rx_good = 1'b1;
                    s_d.tx_ok = 1'b1;
                end else begin
                    s_d.rx_bad = 1'b1;
                end
            end
        end

        // page reader feeding the buffer
        if (!s_q.rd_on && rd_req) begin
            if (rd_first <= rd_last && rd_last <= LAST_PAGE) begin
                s_d.rd_on = 1'b1;
                s_d.rd_pg = rd_first;
                s_d.rd_end = rd_last;
                s_d.rd_by = 2'h0;
                s_d.rd_range = rd_range;
            end else begin
                s_d.rd_err = 1'b1;
            end
        end
        if (s_q.rd_on && s_q.b_cnt != 2'h2) begin
            push = 1'b1;
            push_dat = {s_q.rd_range, s_q.rd_pg == s_q.rd_end && s_q.rd_by == 2'h3,
                        s_q.mem[s_q.rd_pg][{s_q.rd_by, 3'b000} +: 8]};
            s_d.rd_by = s_q.rd_by + 2'h1;
            if (s_q.rd_by == 2'h3) begin
                if (s_q.rd_pg == s_q.rd_end) begin
                    s_d.rd_on = 1'b0;
                end else begin
                    s_d.rd_pg = s_q.rd_pg + 6'h01;
                end
            end
        end else if (rsp_valid && rsp_ready) begin
            push = 1'b1;
            push_dat = {1'b0, rsp_last, rsp_data};
        end

        // page write; one word commits in a single edge so a tear cannot split it
        if (wr_req) begin
            wold = s_q.mem[wr_page];
            gi = (wr_page - PAGE_LOCKED_PAGES) >> 1;
            if (wr_page < PAGE_LOCKED_PAGES) begin
                lk = s_q.mem[LOCK_PAGE][16 + wr_page[3:0]];
            end else begin
                lk = s_q.mem[GLOCK_PAGE][gi[4:0]];
            end
            if (wr_page > LAST_PAGE || wr_page < LOCK_PAGE || lk) begin
                s_d.wr_deny = 1'b1;
            end else begin
                s_d.wr_done = 1'b1;
                case (wr_page)
                    LOCK_PAGE: s_d.mem[wr_page] = wold | {wr_data[31:16], 16'h0000};
                    OTP_PAGE: s_d.mem[wr_page] = wold | wr_data;
                    GLOCK_PAGE: s_d.mem[wr_page] = wold | wr_data;
                    default: s_d.mem[wr_page] = wr_data;
                endcase
            end
        end

        // serialiser
        if (s_q.tx_tmr != 7'h00) s_d.tx_tmr = s_q.tx_tmr - 7'h01;
        case (s_q.tx_st)
            T_IDLE: begin
                if (s_q.tx_ok && has && !s_q.tx_drop) begin
                    pop = 1'b1;
                    ld = 1'b1;
                    ld_first = 1'b1;
                    ld_byte = head[7:0];
                    s_d.tx_last = head[8];
                    s_d.tx_range = head[9];
                    s_d.tx_crc = CRC_INIT;
                    s_d.tx_bits = 11'h000;
                    s_d.tx_cp = 2'h0;
                end
            end
            T_START: begin
                if (s_q.tx_tmr == 7'h00) begin
                    s_d.tx_st = T_DATA;
                    s_d.tx_line = s_q.tx_sh[0];
                    s_d.tx_tmr = BIT_LAST;
                end
            end
            T_DATA: begin
                if (s_q.tx_tmr == 7'h00) begin
                    s_d.tx_tmr = BIT_LAST;
                    if (s_q.tx_i == 3'h7) begin
                        s_d.tx_st = T_PAR;
                        s_d.tx_line = s_q.tx_par;
                    end else begin
                        s_d.tx_sh = s_q.tx_sh >> 1;
                        s_d.tx_line = s_q.tx_sh[1];
                        s_d.tx_i = s_q.tx_i + 3'h1;
                    end
                end
            end
            T_PAR, T_WAIT: begin
                if (s_q.tx_st == T_WAIT || s_q.tx_tmr == 7'h00) begin
                    if (s_q.tx_cp == 2'h2) begin
                        s_d.tx_st = T_IDLE;
                        s_d.tx_line = 1'b0;
                        s_d.tx_act = 1'b0;
                        s_d.tx_ok = 1'b0;
                        s_d.tx_done = 1'b1;
                    end else if (s_q.tx_cp == 2'h1) begin
                        ld = 1'b1;
                        ld_crc = 1'b1;
                        ld_byte = s_q.tx_crc[15:8];
                        s_d.tx_cp = 2'h2;
                    end else if (s_q.tx_last) begin
                        ld = 1'b1;
                        ld_crc = 1'b1;
                        ld_byte = s_q.tx_crc[7:0];
                        s_d.tx_cp = 2'h1;
                    end else if (has) begin
                        pop = 1'b1;
                        // range reads are sized by the reader, fixed answers are capped here
                        if (!head[9] && s_q.tx_bits + TX_TAIL_BITS > TX_MAX_BITS) begin
                            s_d.tx_len_err = 1'b1;
                            s_d.tx_drop = !head[8];
                            ld = 1'b1;
                            ld_crc = 1'b1;
                            ld_byte = s_q.tx_crc[7:0];
                            s_d.tx_cp = 2'h1;
                        end else begin
                            ld = 1'b1;
                            ld_byte = head[7:0];
                            s_d.tx_last = head[8];
                        end
                    end else begin
                        // source underrun: the line rests until the next byte
                        s_d.tx_st = T_WAIT;
                        s_d.tx_line = 1'b0;
                    end
                end
            end
            default: s_d.tx_st = T_IDLE;
        endcase
        if (ld) begin
            s_d.tx_sh = ld_byte;
            s_d.tx_par = ~^ld_byte;
            s_d.tx_i = 3'h0;
            s_d.tx_tmr = BIT_LAST;
            s_d.tx_st = T_DATA;
            s_d.tx_line = ld_byte[0];
            s_d.tx_bits = s_d.tx_bits + 11'h008;
            if (!ld_crc) begin
                s_d.tx_crc = crc_byte(s_q.tx_crc, ld_byte);
            end
        end
        if (ld_first) begin
            s_d.tx_st = T_START;
            s_d.tx_line = 1'b1;
            s_d.tx_act = 1'b1;
            s_d.tx_crc = crc_byte(CRC_INIT, ld_byte);
        end
        // drain the rest of an over-long answer
        if (s_q.tx_drop && has && !pop) begin
            pop = 1'b1;
            if (head[8]) s_d.tx_drop = 1'b0;
        end

        // two-entry buffer bookkeeping
        if (push) begin
            s_d.b_dat[s_q.b_wp] = push_dat;
            s_d.b_wp = !s_q.b_wp;
        end
        if (pop) begin
            s_d.b_rp = !s_q.b_rp;
        end
        s_d.b_cnt = s_q.b_cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_byte_valid = s_q.rx_byte;
    assign rx_byte = s_q.rx_data;
    assign rx_good = s_q.rx_good;
    assign rx_bad = s_q.rx_bad;
    assign rx_short = s_q.rx_short;
    assign rd_busy = s_q.rd_on;
    assign rd_err = s_q.rd_err;
    assign wr_done = s_q.wr_done;
    assign wr_deny = s_q.wr_deny;
    assign tx_line = s_q.tx_line;
    assign tx_active = s_q.tx_act;
    assign tx_done = s_q.tx_done;
    assign tx_len_err = s_q.tx_len_err;
endmodule : frame_layer
`default_nettype wire

/* File: hw/frame_layer_pkg.sv */
// constants, types and the crc step for the contactless frame layer
// assumes a 10 MHz system clock and a demodulator that delivers decoded bit strobes
// Contract
// - every frame opens with one start bit
// - odd parity per byte, none in short frames
// - bits go out least significant first
// - multi-byte values go low byte first
// - page data sent byte 0 to 3, page by page
// - reader frames up to 280 bits accepted
// - fixed responses at most 208 bits
// - bit timing at 106 kbit/s both ways
// - crc, parity, coding and bit count checked
// - 60 pages of 4 bytes, 240 bytes
// - header 16, user 144, config 80 bytes
// - user memory is 36 writable pages
// - lock per page below 16, pairs above
// - 4 otp bytes, bits never clear; reset zeroes them along with the whole page memory
// - lock, otp updates tear-safe
// - crc covers all preceding frame bytes
// - card only answers, never transmits unprompted
package frame_layer_pkg;
    localparam int CLK_HZ = 10_000_000;
    // one bit is 128 carrier periods of 13.56 MHz
    localparam int BIT_NS = 9440;
    localparam int BIT_CYC = BIT_NS / (1_000_000_000 / CLK_HZ);
    localparam logic [6:0] BIT_LAST = 7'(BIT_CYC - 1);
    localparam logic [8:0] RX_MAX_BITS = 9'h118;
    localparam logic [10:0] TX_MAX_BITS = 11'h0D0;
    localparam logic [10:0] TX_TAIL_BITS = 11'h018;
    localparam logic [8:0] SHORT_BITS = 9'h007;
    localparam logic [8:0] MIN_CRC_BITS = 9'h018;
    localparam logic [5:0] LAST_PAGE = 6'h3B;
    localparam logic [5:0] LOCK_PAGE = 6'h02;
    localparam logic [5:0] OTP_PAGE = 6'h03;
    localparam logic [5:0] USER_FIRST = 6'h04;
    localparam logic [5:0] GLOCK_PAGE = 6'h28;
    localparam logic [5:0] PAGE_LOCKED_PAGES = 6'h10;
    localparam logic [15:0] CRC_INIT = 16'h6363;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_WAIT} tx_st_t;

    // reflected crc over one byte, lsb first as on the air
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte
endpackage : frame_layer_pkg

/* File: test/frame_layer_chk.sv */
// checker on the frame layer ports
// assumes one clock and the synchronous reset
`timescale 1ns/100ps
`default_nettype none
module frame_layer_chk
    import frame_layer_pkg::*;
(
    // clock
    input wire logic clk,
    input wire logic reset,
    // receive
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_bit_valid,
    input wire logic rx_code_err,
    input wire logic rx_good,
    input wire logic rx_bad,
    // requests
    input wire logic rd_req,
    input wire logic rd_busy,
    input wire logic [5:0] rd_last,
    input wire logic rd_err,
    input wire logic wr_req,
    input wire logic [5:0] wr_page,
    input wire logic wr_deny,
    // modulator
    input wire logic tx_line,
    input wire logic tx_active,
    input wire logic tx_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [6:0] cyc_q;
    logic perm_q;
    logic cerr_q;
    // bit phase; the line may only move on a bit edge
    always_ff @(posedge clk) begin
        cyc_q <= (!tx_active || cyc_q == BIT_LAST) ? 7'h00 : cyc_q + 7'h01;
        perm_q <= (reset || rx_sof || tx_done) ? 1'b0 : (perm_q || rx_good);
        cerr_q <= (reset || rx_sof) ? 1'b0 : (cerr_q || (rx_bit_valid && rx_code_err));
    end
    property p_start;
        $rose(tx_active) |-> tx_line;
    endproperty
    a_start: assert property (p_start)
        else $error("no start bit");
    property p_bit;
        tx_active && $past(tx_active) && (tx_line != $past(tx_line)) |-> cyc_q == 7'h00;
    endproperty
    a_bit: assert property (p_bit)
        else $error("bit edge off the bit time");
    property p_idle;
        !tx_active |-> !tx_line;
    endproperty
    a_idle: assert property (p_idle)
        else $error("line moves outside a frame");
    property p_prompt;
        $rose(tx_active) |-> perm_q;
    endproperty
    a_prompt: assert property (p_prompt)
        else $error("reply without a good frame");
    property p_verdict;
        rx_eof |=> rx_good ^ rx_bad;
    endproperty
    a_verdict: assert property (p_verdict)
        else $error("no single verdict after end of frame");
    property p_cause;
        rx_good || rx_bad |-> $past(rx_eof);
    endproperty
    a_cause: assert property (p_cause)
        else $error("verdict without end of frame");
    property p_code;
        rx_eof && cerr_q |=> rx_bad;
    endproperty
    a_code: assert property (p_code)
        else $error("coding error accepted");
    property p_wr;
        wr_req && (wr_page < 6'h02 || wr_page > LAST_PAGE) |=> wr_deny;
    endproperty
    a_wr: assert property (p_wr)
        else $error("header or missing page written");
    property p_rd;
        rd_req && !rd_busy && rd_last > LAST_PAGE |=> rd_err;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read past last page taken");
endmodule : frame_layer_chk
`default_nettype wire

/* File: test/reader_model.sv */
// reader model: sends framed bits and decodes the replies
// assumes decoded bit strobes toward the card, mid-bit sampling back
`timescale 1ns/100ps
`default_nettype none
module reader_model
    import frame_layer_pkg::*;
(
    // clock
    input wire logic clk,
    // toward the card
    output logic rx_sof,
    output logic rx_bit_valid,
    output logic rx_bit,
    output logic rx_code_err,
    output logic rx_eof,
    // from the card
    input wire logic tx_line,
    input wire logic tx_active,
    output logic got_valid,
    output logic [7:0] got_byte,
    output logic got_perr
);
    int gap = 4;
    int n;
    logic [8:0] sh;
    initial begin
        {rx_sof, rx_bit_valid, rx_bit, rx_code_err, rx_eof, got_valid} = 6'h00;
    end
    // gap of at least 2 keeps the strobe from being cleared and set again in one step
    task automatic strobe(input logic b, input logic ce);
        repeat (gap - 1) @(posedge clk);
        rx_bit_valid <= 1'b1;
        rx_bit <= b;
        rx_code_err <= ce;
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        rx_code_err <= 1'b0;
        rx_bit <= ~b;
    endtask : strobe
    task automatic send(input logic [7:0] d[$], input int perr, input int cerr, input bit sf);
        rx_sof <= 1'b1;
        @(posedge clk);
        rx_sof <= 1'b0;
        foreach (d[i]) begin
            for (int k = 0; k < (sf ? 7 : 8); k++) strobe(d[i][k], i * 8 + k == cerr);
            if (!sf) strobe(~^d[i] ^ (i == perr), 1'b0);
        end
        repeat (gap) @(posedge clk);
        rx_eof <= 1'b1;
        @(posedge clk);
        rx_eof <= 1'b0;
    endtask : send
    // nine bits to a byte, lsb first, parity last
    always begin
        @(posedge clk iff tx_active);
        n = 0;
        repeat (BIT_CYC / 2) @(posedge clk);
        while (tx_active) begin
            // clear one edge into the bit so the strobe is never set and cleared in one step
            @(posedge clk);
            got_valid <= 1'b0;
            repeat (BIT_CYC - 1) @(posedge clk);
            sh = {tx_line, sh[8:1]};
            n++;
            if (tx_active && n % 9 == 0) begin
                got_valid <= 1'b1;
                got_byte <= sh[7:0];
                got_perr <= ~^sh;
            end
        end
    end
endmodule : reader_model
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the frame layer
// assumes the checker and reader model are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench
    import frame_layer_pkg::*;
;
    typedef logic [7:0] bytes_t[$];
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic rx_sof, rx_bit_valid, rx_bit, rx_code_err, rx_eof, got_valid, got_perr;
    logic [7:0] got_byte, rx_byte;
    logic rx_byte_valid, rx_good, rx_bad, rx_short, rsp_ready, rd_busy, rd_err, wr_done, wr_deny;
    logic tx_line, tx_active, tx_done, tx_len_err;
    logic rsp_valid = 1'b0, rsp_last = 1'b0, rd_req = 1'b0, rd_range = 1'b0, wr_req = 1'b0;
    logic [7:0] rsp_data = 8'h00;
    logic [5:0] rd_first = 6'h00, rd_last = 6'h00, wr_page = 6'h00;
    logic [31:0] wr_data = 32'h0000_0000;
    int n_fail = 0;
    int num_checks = 0;
    bytes_t rxq, txq;
    logic [4:0] eq[$];
    bit skip_tx = 1'b0;
    bit len_seen = 1'b0;
    always #50 clk = ~clk;
    frame_layer i_dut (.clk, .reset, .rx_sof, .rx_bit_valid, .rx_bit, .rx_code_err, .rx_eof, .rx_byte_valid,
        .rx_byte, .rx_good, .rx_bad, .rx_short, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready, .rd_req, .rd_first,
        .rd_last, .rd_range, .rd_busy, .rd_err, .wr_req, .wr_page, .wr_data, .wr_done, .wr_deny, .tx_line,
        .tx_active, .tx_done, .tx_len_err);
    reader_model i_rdr (.clk, .rx_sof, .rx_bit_valid, .rx_bit, .rx_code_err, .rx_eof, .tx_line, .tx_active,
        .got_valid, .got_byte, .got_perr);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic tmo;
        n_fail++;
        $display("mismatch at %0t: wait ran out", $time);
        end_of_test();
    endtask : tmo
    function automatic bytes_t rnd(input int n);
        bytes_t q;
        repeat (n) q.push_back(8'($urandom));
        return q;
    endfunction : rnd
    function automatic bytes_t withcrc(input bytes_t d);
        logic [15:0] c = 16'h6363;
        foreach (d[i]) begin
            c ^= {8'h00, d[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        d.push_back(c[7:0]);
        d.push_back(c[15:8]);
        return d;
    endfunction : withcrc
    always @(posedge clk) begin
        if (rx_byte_valid && rxq.size() > 0) check(rx_byte, rxq.pop_front());
        if ({rd_err, wr_done, wr_deny, rx_good, rx_bad} != 5'h00)
            check({rd_err, wr_done, wr_deny, rx_good, rx_bad}, eq.size() > 0 ? eq.pop_front() : 5'h1f);
        if (tx_len_err) len_seen = 1'b1;
        if (got_valid && !skip_tx)
            check({got_perr, got_byte}, txq.size() > 0 ? {1'b0, txq.pop_front()} : 9'h1ff);
    end
    task automatic frame(input bytes_t d, input int perr, input int cerr, input bit sf, input logic [4:0] ev);
        eq.push_back(ev);
        if (ev == 5'h02) foreach (d[i]) rxq.push_back(d[i]);
        i_rdr.send(d, perr, cerr, sf);
        repeat (4) @(posedge clk);
        check(rxq.size(), 0);
    endtask : frame
    task automatic respond(input bytes_t d);
        bytes_t e;
        int t;
        e = withcrc(d);
        if (!skip_tx) foreach (e[i]) txq.push_back(e[i]);
        foreach (d[i]) begin
            rsp_valid <= 1'b1;
            rsp_data <= d[i];
            rsp_last <= (i == d.size() - 1);
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (rsp_ready !== 1'b1 && t < 5000);
            if (t >= 5000) tmo();
        end
        rsp_valid <= 1'b0;
    endtask : respond
    task automatic wait_done;
        int t = 0;
        while (tx_done !== 1'b1 && t < 40000) begin
            @(posedge clk);
            t++;
        end
        if (t >= 40000) tmo();
        repeat (2) @(posedge clk);
    endtask : wait_done
    task automatic wr(input logic [5:0] p, input logic [31:0] v, input logic [4:0] ev);
        eq.push_back(ev);
        wr_req <= 1'b1;
        wr_page <= p;
        wr_data <= v;
        @(posedge clk);
        wr_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wr
    task automatic rd(input logic [5:0] f, input logic [5:0] l, input logic [4:0] ev, input bit rng = 1'b0);
        if (ev != 5'h00) eq.push_back(ev);
        rd_req <= 1'b1;
        rd_first <= f;
        rd_last <= l;
        rd_range <= rng;
        @(posedge clk);
        rd_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : rd
    initial begin
        bytes_t a, b, d;
        void'($urandom(32'h0000_b0c7));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check({rsp_ready, tx_active, rd_busy}, 3'h4);
        a = rnd(4);
        b = rnd(4);
        wr(6'h04, {a[3], a[2], a[1], a[0]}, 5'h08);
        wr(6'h05, {b[3], b[2], b[1], b[0]}, 5'h08);
        wr(6'h00, 32'h0000_0000, 5'h04);
        wr(6'h01, 32'h0000_0001, 5'h04);
        wr(6'h3c, 32'h0000_0002, 5'h04);
        // lock bit of page 6, then group lock of pages 16 and 17
        wr(6'h02, 32'h0040_0000, 5'h08);
        wr(6'h06, 32'h0000_0003, 5'h04);
        wr(6'h28, 32'h0000_0001, 5'h08);
        wr(6'h11, 32'h0000_0004, 5'h04);
        wr(6'h12, 32'h0000_0005, 5'h08);
        wr(6'h03, 32'h0000_00f0, 5'h08);
        wr(6'h03, 32'h0000_000f, 5'h08);
        wr(6'h03, 32'h0000_0000, 5'h08);
        i_rdr.gap = BIT_CYC;
        frame(withcrc(rnd(3)), -1, -1, 1'b0, 5'h02);
        i_rdr.gap = 4;
        respond(rnd(3));
        wait_done();
        check(len_seen, 1'b0);
        frame(withcrc(rnd(2)), -1, -1, 1'b0, 5'h02);
        // three pages stay well inside the fixed answer cap
        d = {8'hff, 8'h00, 8'h00, 8'h00};
        d = {d, a, b};
        d = withcrc(d);
        foreach (d[i]) txq.push_back(d[i]);
        rd(6'h03, 6'h05, 5'h00);
        wait_done();
        // a range read of seven pages runs past the fixed answer cap and must not be cut
        frame(withcrc(rnd(2)), -1, -1, 1'b0, 5'h02);
        d = {a, b};
        repeat (20) d.push_back(8'h00);
        d = withcrc(d);
        foreach (d[i]) txq.push_back(d[i]);
        rd(6'h04, 6'h0a, 5'h00, 1'b1);
        wait_done();
        check(len_seen, 1'b0);
        rd(6'h06, 6'h05, 5'h10);
        rd(6'h00, 6'h3c, 5'h10);
        frame(withcrc(rnd(3)), 1, -1, 1'b0, 5'h01);
        frame(withcrc(rnd(3)), -1, 10, 1'b0, 5'h01);
        d = withcrc(rnd(3));
        d[3] = ~d[3];
        frame(d, -1, -1, 1'b0, 5'h01);
        respond(rnd(2));
        repeat (300) @(posedge clk);
        check(tx_active, 1'b0);
        frame(withcrc(rnd(33)), -1, -1, 1'b0, 5'h02);
        wait_done();
        frame(withcrc(rnd(34)), -1, -1, 1'b0, 5'h01);
        d = {8'h26};
        frame(d, -1, -1, 1'b1, 5'h02);
        check(rx_short, 1'b1);
        frame(withcrc(rnd(1)), -1, -1, 1'b0, 5'h02);
        skip_tx = 1'b1;
        respond(rnd(25));
        wait_done();
        check(len_seen, 1'b1);
        check(txq.size() + eq.size() + rxq.size(), 0);
        end_of_test();
    end
endmodule : testbench
bind frame_layer frame_layer_chk i_chk (.clk, .reset, .rx_sof, .rx_eof, .rx_bit_valid, .rx_code_err, .rx_good,
    .rx_bad, .rd_req, .rd_busy, .rd_last, .rd_err, .wr_req, .wr_page, .wr_deny, .tx_line, .tx_active, .tx_done);
`default_nettype wire
